// >>> logic/analogue_output_scaler.sv
// Analogue output scaler: maps the measurement onto a current or voltage span,
// clamps it, forces alarm levels, and accepts a bus setpoint with frame supervision.
// Assumes measurement, peak value and frame strobe are synchronous to aclk.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps

module analogue_output_scaler
  import aout_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_ACTIVE_I,
  parameter int SECOND_CYCLES = SECOND_CYC
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic signed [15:0] measured_value, // Live measurement
  input wire logic signed [15:0] peak_value, // Held peak or drop
  input wire logic range_exceeded, // Measurement range overflow
  input wire logic frame_received, // Pulse per valid serial frame
  output logic [15:0] dac_code, // Converter code
  output logic [3:0] relay_setpoint // Bus relay state
);

  initial begin
    if (VARIANT > VAR_VOLT) $error("VARIANT out of range");
    if (SECOND_CYCLES < 1) $error("SECOND_CYCLES must be positive");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    cfg_s cfg;
    logic [15:0] setpoint;
    logic [3:0] relay;
    logic [31:0] sec_cnt;
    logic [6:0] gap_sec;
    logic gap_alarm;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] out;
  } state_s;

  state_s st;
  state_s next_st;

  localparam logic [15:0] ZERO16 = 16'h0000;

  // Span limits and clamp borders
  logic [15:0] span_a;
  logic [15:0] span_b;
  logic [31:0] border_lo;
  logic [31:0] border_hi;
  logic signed [47:0] num;
  logic signed [31:0] den;
  logic signed [47:0] quo;
  logic signed [47:0] raw;
  logic [15:0] clamped;
  logic [15:0] crit_level;
  logic crit_hold;
  logic critical;
  logic mode_ok;
  logic cfg_write_ok;
  logic signed [15:0] sel_value;

  always_comb begin
    span_a = ZERO16;
    span_b = ZERO16;
    mode_ok = 1'b1;
    case (st.cfg.mode)
      MODE_I0_20: begin
        span_b = I_20MA;
        mode_ok = (VARIANT == VAR_ACTIVE_I);
      end
      MODE_I4_20: begin
        span_a = I_4MA;
        span_b = I_20MA;
        mode_ok = (VARIANT != VAR_VOLT);
      end
      MODE_V0_5: begin
        span_b = V_5V;
        mode_ok = (VARIANT == VAR_VOLT);
      end
      MODE_V1_5: begin
        span_a = V_1V;
        span_b = V_5V;
        mode_ok = (VARIANT == VAR_VOLT);
      end
      MODE_V0_10: begin
        span_b = V_10V;
        mode_ok = (VARIANT == VAR_VOLT);
      end
      MODE_V2_10: begin
        span_a = V_2V;
        span_b = V_10V;
        mode_ok = (VARIANT == VAR_VOLT);
      end
      MODE_BUS: mode_ok = 1'b1;
      default: mode_ok = 1'b0;
    endcase
  end

  always_comb begin
    // Borders scaled by 1000 to keep 0.1 percent steps exact
    border_lo = 32'(span_a) * 32'd1000 - 32'(span_a) * 32'(st.cfg.lower_range_extension);
    border_hi = 32'(span_b) * 32'd1000 + 32'(span_b) * 32'(st.cfg.upper_range_extension);
    sel_value = st.cfg.source_peak ? peak_value : measured_value;
    den = 32'(st.cfg.high_input_point) - 32'(st.cfg.low_input_point);
    // Signed division handles a reversed characteristic naturally
    num = 48'(32'(sel_value) - 32'(st.cfg.low_input_point)) *
      48'(32'(span_b) - 32'(span_a)) * 48'sd1000;
    quo = (den == 32'sd0) ? 48'sd0 : num / 48'(den);
    raw = quo + 48'(32'(span_a) * 32'd1000);
    // Borders are compared signed so a computed value below zero clamps low
    if (raw < $signed(48'(border_lo))) begin
      clamped = 16'(border_lo / 32'd1000);
    end else if (raw > $signed(48'(border_hi))) begin
      clamped = 16'(border_hi / 32'd1000);
    end else begin
      clamped = 16'(raw / 48'sd1000);
    end
  end

  always_comb begin
    crit_hold = 1'b0;
    crit_level = ZERO16;
    if (VARIANT == VAR_VOLT) begin
      case (st.cfg.critical_level_select)
        CRIT_HOLD: crit_hold = 1'b1;
        CRIT_L1: crit_level = V_11;
        CRIT_L2: crit_level = V_5_5;
        CRIT_L3: crit_level = V_1_2;
        CRIT_L4: crit_level = V_0_6;
        default: crit_level = ZERO16;
      endcase
    end else begin
      case (st.cfg.critical_level_select)
        CRIT_HOLD: crit_hold = 1'b1;
        CRIT_L1: crit_level = I_22_1;
        CRIT_L2: crit_level = I_3_4;
        default: crit_level = ZERO16;
      endcase
    end
  end

  assign critical = (st.cfg.mode == MODE_BUS) ? st.gap_alarm : range_exceeded;
  assign cfg_write_ok = st.cfg.bus_config_access;

  // Accepts a config value only when it fits this variant
  function automatic logic crit_legal(input logic [2:0] c);
    crit_legal = (VARIANT == VAR_VOLT) ? (c <= CRIT_L5) :
      (VARIANT == VAR_ACTIVE_I) ? (c <= CRIT_L3) : (c <= CRIT_L2);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] wlo;
    wlo = 16'h0000;
    next_st = st;
    // Frame gap supervision
    if (frame_received || st.cfg.frame_gap_timeout == 7'd0) begin
      next_st.sec_cnt = 32'd0;
      next_st.gap_sec = 7'd0;
      next_st.gap_alarm = 1'b0;
    end else if (st.sec_cnt == 32'(SECOND_CYCLES - 1)) begin
      next_st.sec_cnt = 32'd0;
      if (st.gap_sec >= st.cfg.frame_gap_timeout) begin
        next_st.gap_alarm = 1'b1;
      end else begin
        next_st.gap_sec = st.gap_sec + 7'd1;
      end
    end else begin
      next_st.sec_cnt = st.sec_cnt + 32'd1;
    end

    // AXI write: address and data captured independently
    if (s_axi_awvalid && !st.aw_hold) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_hold) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.aw_hold && st.w_hold && !st.bvalid) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      wlo = st.w_data[15:0];
      if (!(&st.w_strb[1:0]) && st.aw_addr != REG_RELAY) begin
        next_st.bresp = RESP_SLVERR;
      end else begin
        case (st.aw_addr)
          REG_SETPOINT: next_st.cfg = st.cfg; // Never blocked by access switch
          REG_RELAY: next_st.cfg = st.cfg;
          REG_STATUS: next_st.bresp = RESP_SLVERR;
          default: if (!cfg_write_ok && st.aw_addr != REG_FRAME) begin
            next_st.bresp = RESP_SLVERR;
          end
        endcase
        case (st.aw_addr)
          REG_SETPOINT: next_st.setpoint = wlo;
          REG_RELAY: if (st.w_strb[0]) begin
            next_st.relay = st.w_data[3:0];
          end
          REG_MODE: if (cfg_write_ok) begin
            next_st.cfg.mode = wlo[2:0];
            next_st.cfg.source_peak = wlo[4];
            next_st.cfg.bus_config_access = wlo[8];
          end
          REG_LOW_PT: if (cfg_write_ok) next_st.cfg.low_input_point = wlo;
          REG_HIGH_PT: if (cfg_write_ok) next_st.cfg.high_input_point = wlo;
          REG_EXT: if (cfg_write_ok) begin
            if (st.w_data[9:0] <= ((VARIANT == VAR_PASSIVE_I) ? EXT_LO_MAX_PAS :
                EXT_LO_MAX_ACT)) next_st.cfg.lower_range_extension = st.w_data[9:0];
            if (st.w_data[25:16] <= ((VARIANT == VAR_VOLT) ? EXT_HI_MAX_V :
                EXT_HI_MAX_I)) next_st.cfg.upper_range_extension = st.w_data[25:16];
          end
          REG_CRIT: if (cfg_write_ok && crit_legal(wlo[2:0])) begin
            next_st.cfg.critical_level_select = wlo[2:0];
          end
          REG_TIMEOUT: if (cfg_write_ok && wlo[6:0] <= TIMEOUT_MAX) begin
            next_st.cfg.frame_gap_timeout = wlo[6:0];
          end
          default: next_st.setpoint = st.setpoint;
        endcase
      end
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;

    // AXI read
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      next_st.rdata = 32'h00000000;
      case (s_axi_araddr)
        REG_MODE: next_st.rdata = {23'h0, st.cfg.bus_config_access, 3'h0,
          st.cfg.source_peak, 1'b0, st.cfg.mode};
        REG_LOW_PT: next_st.rdata = {16'h0, st.cfg.low_input_point};
        REG_HIGH_PT: next_st.rdata = {16'h0, st.cfg.high_input_point};
        REG_EXT: next_st.rdata = {6'h0, st.cfg.upper_range_extension, 6'h0,
          st.cfg.lower_range_extension};
        REG_CRIT: next_st.rdata = {29'h0, st.cfg.critical_level_select};
        REG_TIMEOUT: next_st.rdata = {25'h0, st.cfg.frame_gap_timeout};
        REG_SETPOINT: next_st.rdata = {16'h0, st.setpoint};
        REG_STATUS: next_st.rdata = {st.out, 13'h0, mode_ok, critical, st.gap_alarm};
        REG_RELAY: next_st.rdata = {28'h0, st.relay};
        default: next_st.rresp = RESP_SLVERR;
      endcase
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // Output selection
    if (st.cfg.mode == MODE_OFF || !mode_ok) begin
      next_st.out = ZERO16;
    end else if (critical) begin
      if (!crit_hold) next_st.out = crit_level;
    end else if (st.cfg.mode == MODE_BUS) begin
      next_st.out = st.setpoint;
    end else begin
      next_st.out = clamped;
    end

    if (!aresetn) begin
      next_st = '0;
      next_st.cfg.high_input_point = 16'sd1000;
      next_st.cfg.bus_config_access = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  assign s_axi_awready = !st.aw_hold;
  assign s_axi_wready = !st.w_hold;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign dac_code = st.out;
  assign relay_setpoint = st.relay;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_off_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.mode == MODE_OFF |=> dac_code == 16'h0000) else $error("off mode not zero");
  a_bus_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.mode == MODE_BUS && !critical |=> dac_code == $past(st.setpoint))
    else $error("bus setpoint not followed");
  a_clamp_hi: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ok && st.cfg.mode != MODE_BUS && st.cfg.mode != MODE_OFF && !critical
    |=> 32'(dac_code) * 32'd1000 <= $past(border_hi)) else $error("above upper border");
  a_clamp_lo: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ok && st.cfg.mode != MODE_BUS && st.cfg.mode != MODE_OFF && !critical
    |=> 32'(dac_code) * 32'd1000 + 32'd999 >= $past(border_lo)) else $error("below border");
  a_crit_level: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ok && st.cfg.mode != MODE_OFF && critical && !crit_hold
    |=> dac_code == $past(crit_level)) else $error("alarm level wrong");
  a_crit_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    mode_ok && st.cfg.mode != MODE_OFF && critical && crit_hold |=> $stable(dac_code))
    else $error("hold level moved");
  a_gap_off: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.frame_gap_timeout == 7'd0 |=> !st.gap_alarm) else $error("gap alarm when off");
  a_frame_clr: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_received |=> !st.gap_alarm ##1 (st.gap_sec == 7'd0 || frame_received ||
    st.gap_sec == 7'd1)) else $error("frame did not clear gap");
  a_cfg_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_write_ok && !s_axi_arvalid |=> $stable(st.cfg)) else $error("locked config changed");

endmodule

// >>> logic/aout_pkg.sv
// Package for the analogue output scaler: register map, field codes, constants.
// Assumes a 10 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package aout_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_LOW_PT = 8'h04;
  localparam logic [7:0] REG_HIGH_PT = 8'h08;
  localparam logic [7:0] REG_EXT = 8'h0C;
  localparam logic [7:0] REG_CRIT = 8'h10;
  localparam logic [7:0] REG_TIMEOUT = 8'h14;
  localparam logic [7:0] REG_SETPOINT = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_RELAY = 8'h20;
  localparam logic [7:0] REG_FRAME = 8'h24;

  // ----------------------------------------------------------------
  // Output variants and modes
  // ----------------------------------------------------------------
  localparam logic [1:0] VAR_ACTIVE_I = 2'h0;
  localparam logic [1:0] VAR_PASSIVE_I = 2'h1;
  localparam logic [1:0] VAR_VOLT = 2'h2;

  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_I0_20 = 3'h1;
  localparam logic [2:0] MODE_I4_20 = 3'h2;
  localparam logic [2:0] MODE_BUS = 3'h3;
  localparam logic [2:0] MODE_V0_5 = 3'h4;
  localparam logic [2:0] MODE_V1_5 = 3'h5;
  localparam logic [2:0] MODE_V0_10 = 3'h6;
  localparam logic [2:0] MODE_V2_10 = 3'h7;

  // Critical level select codes (index into level table)
  localparam logic [2:0] CRIT_HOLD = 3'h0;
  localparam logic [2:0] CRIT_L1 = 3'h1;
  localparam logic [2:0] CRIT_L2 = 3'h2;
  localparam logic [2:0] CRIT_L3 = 3'h3;
  localparam logic [2:0] CRIT_L4 = 3'h4;
  localparam logic [2:0] CRIT_L5 = 3'h5;

  // ----------------------------------------------------------------
  // Output codes: current in 1/256 mA, voltage in 1/512 V (Q8.8 / Q7.9)
  // ----------------------------------------------------------------
  localparam logic [15:0] I_20MA = 16'h1400;
  localparam logic [15:0] I_4MA = 16'h0400;
  localparam logic [15:0] I_22_1 = 16'h161A;
  localparam logic [15:0] I_3_4 = 16'h0366;
  localparam logic [15:0] V_5V = 16'h0A00;
  localparam logic [15:0] V_10V = 16'h1400;
  localparam logic [15:0] V_1V = 16'h0200;
  localparam logic [15:0] V_2V = 16'h0400;
  localparam logic [15:0] V_11 = 16'h1600;
  localparam logic [15:0] V_5_5 = 16'h0B00;
  localparam logic [15:0] V_1_2 = 16'h0266;
  localparam logic [15:0] V_0_6 = 16'h0133;

  // Extension limits in 0.1 percent steps; frame gap timeout limit in seconds
  localparam logic [9:0] EXT_LO_MAX_ACT = 10'd999;
  localparam logic [9:0] EXT_LO_MAX_PAS = 10'd299;
  localparam logic [9:0] EXT_HI_MAX_I = 10'd199;
  localparam logic [9:0] EXT_HI_MAX_V = 10'd99;
  localparam logic [6:0] TIMEOUT_MAX = 7'd99;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYC = CLK_HZ * SECOND_S;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] mode;
    logic source_peak;
    logic bus_config_access;
    logic signed [15:0] low_input_point;
    logic signed [15:0] high_input_point;
    logic [9:0] lower_range_extension;
    logic [9:0] upper_range_extension;
    logic [2:0] critical_level_select;
    logic [6:0] frame_gap_timeout;
  } cfg_s;

endpackage

// >>> tb/analogue_output_scaler_tb.sv
// Self-checking bench for the analogue output scaler.
// Assumes the package and the converter model are compiled first.
`timescale 1ns/10ps

module analogue_output_scaler_tb;
  import aout_pkg::*;

  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
    logic [31:0] mask;
    logic dac;
  } note_s;

  localparam logic [15:0] MV[4] = '{16'h00AF, 16'h00CD, 16'h012C, 16'h0032};
  localparam logic [15:0] EV[4] = '{16'h1000, 16'h14CC, 16'h1500, 16'h03CC};
  localparam logic [15:0] CL[4] = '{16'h1000, I_22_1, I_3_4, 16'h0000};

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic signed [15:0] meas = 16'sh0, peak = 16'sh0;
  logic rng_exc = 1'b0, frame = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] dac_code;
  logic [3:0] relay;
  logic [15:0] seed = 16'hCC4F; // LFSR start 52303
  int level;
  int err_count = 0, n_compared = 0;
  note_s wq[$], rq[$];

  always #50 aclk = ~aclk;

  analogue_output_scaler #(.VARIANT(VAR_ACTIVE_I), .SECOND_CYCLES(20)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .measured_value(meas), .peak_value(peak), .range_exceeded(rng_exc),
    .frame_received(frame), .dac_code(dac_code), .relay_setpoint(relay));

  loop_converter #(.VARIANT(VAR_ACTIVE_I)) conv (.aclk(aclk), .code(dac_code), .level(level));

  // ----------------------------------------------------------------
  // Helpers and bus tasks
  // ----------------------------------------------------------------
  task automatic bad(input string m);
    err_count++;
    $display("BAD t=%0t %s", $time, m);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    wq.push_back('{r, 32'h0, 32'h0, 1'b0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r, input logic dc);
    rq.push_back('{r, d, m, dc});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask

  // Two cycles let an input change reach the registered code first
  task automatic dac_is(input logic [15:0] e);
    step(2);
    rd(REG_STATUS, {e, 16'h0000}, 32'hFFFF_0000, RESP_OKAY, 1'b1);
  endtask

  task automatic pulse();
    @(posedge aclk);
    frame <= 1'b1;
    @(posedge aclk);
    frame <= 1'b0;
  endtask

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    note_s n;
    if (bvalid && bready) begin
      n = wq.pop_front();
      n_compared++;
      if (bresp !== n.resp) bad("write response");
    end
    if (rvalid && rready) begin
      n = rq.pop_front();
      n_compared++;
      if (rresp !== n.resp || (rdata & n.mask) !== n.data) bad("read data");
      if (n.dac && dac_code !== n.data[31:16]) bad("converter code");
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] d;
    step(4);
    aresetn <= 1'b1;
    rd(REG_MODE, 32'h0000_0100, 32'hFFFF_FFFF, RESP_OKAY, 1'b0);
    rd(REG_SETPOINT, 32'h0, 32'hFFFF_FFFF, RESP_OKAY, 1'b0);
    meas <= 16'sh00AF;
    dac_is(16'h0000);
    rd(8'h30, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR, 1'b0);
    wr(REG_STATUS, 32'h0, RESP_SLVERR);
    wr(REG_LOW_PT, 32'h64, RESP_OKAY);
    wr(REG_HIGH_PT, 32'hC8, RESP_OKAY);
    wr(REG_EXT, 32'h0032_0032, RESP_OKAY);
    // Lower field 100.0% is out of range and must be ignored; upper keeps 5.0%
    wr(REG_EXT, 32'h0032_03E8, RESP_OKAY);
    wr(REG_MODE, 32'h104, RESP_OKAY);
    dac_is(16'h0000);
    wr(REG_MODE, 32'h102, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      meas <= MV[i];
      dac_is(EV[i]);
    end
    wr(REG_LOW_PT, 32'hC8, RESP_OKAY);
    wr(REG_HIGH_PT, 32'h64, RESP_OKAY);
    meas <= 16'sh00AF;
    dac_is(16'h0800);
    wr(REG_LOW_PT, 32'h64, RESP_OKAY);
    wr(REG_HIGH_PT, 32'hC8, RESP_OKAY);
    wr(REG_MODE, 32'h101, RESP_OKAY);
    meas <= 16'sh0096;
    dac_is(16'h0A00);
    peak <= 16'sh00AF;
    wr(REG_MODE, 32'h111, RESP_OKAY);
    dac_is(16'h0F00);
    wr(REG_MODE, 32'h101, RESP_OKAY);
    wr(REG_LOW_PT, 32'h0, RESP_OKAY);
    wr(REG_HIGH_PT, 32'h3E8, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = seed % 16'h03E9;
      meas <= d;
      dac_is(16'((int'(d) * 32'h1400) / 32'h3E8));
    end
    wr(REG_MODE, 32'h102, RESP_OKAY);
    wr(REG_LOW_PT, 32'h64, RESP_OKAY);
    wr(REG_HIGH_PT, 32'hC8, RESP_OKAY);
    meas <= 16'sh00AF;
    rng_exc <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      wr(REG_CRIT, 32'(c), RESP_OKAY);
      dac_is(CL[c]);
      if (c == 1) begin
        n_compared++;
        if (level < 22095 || level > 22105) bad("loop level");
      end
    end
    rng_exc <= 1'b0;
    dac_is(16'h1000);
    wr(REG_CRIT, 32'h0, RESP_OKAY);
    rng_exc <= 1'b1;
    dac_is(16'h1000);
    meas <= 16'sh00CD;
    dac_is(16'h1000);
    rng_exc <= 1'b0;
    dac_is(16'h14CC);
    wr(REG_CRIT, 32'h1, RESP_OKAY);
    wr(REG_TIMEOUT, 32'h1, RESP_OKAY);
    wr(REG_SETPOINT, 32'h1234, RESP_OKAY);
    pulse();
    wr(REG_MODE, 32'h103, RESP_OKAY);
    rng_exc <= 1'b1;
    step(20);
    dac_is(16'h1234);
    step(15);
    dac_is(I_22_1);
    pulse();
    dac_is(16'h1234);
    wr(REG_TIMEOUT, 32'h0, RESP_OKAY);
    pulse();
    step(60);
    dac_is(16'h1234);
    rng_exc <= 1'b0;
    wr(REG_MODE, 32'h003, RESP_OKAY);
    wr(REG_LOW_PT, 32'h10, RESP_SLVERR);
    wr(REG_SETPOINT, 32'h0800, RESP_OKAY);
    dac_is(16'h0800);
    wr(REG_RELAY, 32'hA, RESP_OKAY);
    step(2);
    n_compared++;
    if (relay !== 4'hA) bad("relay bits");
    wr(REG_MODE, 32'h103, RESP_SLVERR);
    rd(REG_MODE, 32'h0000_0003, 32'h0000_01FF, RESP_OKAY, 1'b0);
    step(4);
    if (wq.size() != 0 || rq.size() != 0) bad("results missing");
    final_report();
  end

  initial begin
    step(5000);
    bad("watchdog expired");
    final_report();
  end
endmodule

// >>> tb/loop_converter.sv
// Behavioural model of the converter that drives the external loop.
// Assumes the code arrives registered on aclk from the scaler.
`timescale 1ns/10ps

module loop_converter
  import aout_pkg::*;
#(
  parameter logic [1:0] VARIANT = VAR_ACTIVE_I
) (
  input wire logic aclk, // System clock
  input wire logic [15:0] code, // Code from the scaler
  output int level // Loop level in uA or mV
);
  // ----------------------------------------------------------------
  // Conversion
  // ----------------------------------------------------------------
  // Settles in one cycle; a real converter ramps, so checks allow slack
  always @(posedge aclk) begin
    if (VARIANT == VAR_VOLT) begin
      level <= int'(code) * 32'h3E8 / 32'h200;
    end else begin
      level <= int'(code) * 32'h3E8 / 32'h100;
    end
  end
endmodule
